/* inc/bcdm_pkg.sv */
package bcdm_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DEPTH = 82;
  localparam logic [6:0] ADDR_MIN = 7'h02;
  localparam logic [6:0] ADDR_MAX = 7'h53;
  // read access time, microseconds
  localparam int unsigned READ_ACCESS_US = 100;
  localparam int unsigned READ_ACCESS_CYC = READ_ACCESS_US * (CLK_HZ / 1_000_000);
  // address setup time kept by the controller, microseconds
  localparam int unsigned ADDR_SETUP_US = 20;
  // counts in timing-reference periods (200 Hz nominal, 5 ms each)
  // four edges keep the debounce inside 12.5 to 37.5 ms for any phase
  localparam logic [7:0] DEBOUNCE_TICKS = 8'h04;
  localparam logic [7:0] RELEASE_TICKS = 8'h03;
  localparam logic [7:0] ALTER_TICKS = 8'h28;
  localparam logic [7:0] LOCKOUT_TICKS = 8'h03;
  localparam logic STORE_RESET = 1'b0;
endpackage

/* tb/bcdm_tuner.sv */
`timescale 1ns/100ps
module bcdm_tuner
  import bcdm_pkg::*;
#(
  parameter int unsigned REF_HALF = 20
) (
  input wire logic clock_i,
  output logic [3:0] low_digit_lines_o,
  output logic [3:0] high_digit_lines_o,
  output logic chip_select_n_o,
  output logic set_zero_n_o,
  output logic set_one_n_o,
  output logic timing_reference_o
);
  int unsigned ref_cnt = 0;
  initial begin
    {high_digit_lines_o, low_digit_lines_o} = 8'h00;
    chip_select_n_o = 1'h1;
    set_zero_n_o = 1'h1;
    set_one_n_o = 1'h1;
    timing_reference_o = 1'h0;
  end
  // rc timing reference, scaled down to keep runs short
  always @(posedge clock_i) begin
    ref_cnt <= (ref_cnt + 1) % REF_HALF;
    if (ref_cnt == REF_HALF - 1) begin
      timing_reference_o <= ~timing_reference_o;
    end
  end
  // caller moves the address only while select is high
  task automatic set_addr(input logic [7:0] a);
    @(posedge clock_i);
    {high_digit_lines_o, low_digit_lines_o} <= a;
  endtask
  task automatic select(input logic v);
    @(posedge clock_i);
    chip_select_n_o <= v;
  endtask
  // open contacts return to the pull-up level
  task automatic contact(input logic z, input logic o);
    @(posedge clock_i);
    set_zero_n_o <= z;
    set_one_n_o <= o;
  endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import bcdm_pkg::*;
  localparam int REF_P = 40;
  localparam int SETUP = ADDR_SETUP_US * (CLK_HZ / 1_000_000);
  logic clock_i = 1'h0;
  logic rst_i = 1'h1;
  logic [3:0] lo_d;
  logic [3:0] hi_d;
  logic cs_n;
  logic sz_n;
  logic so_n;
  logic ref_c;
  logic data_out_o;
  logic altering_o;
  logic ce_r = 1'h1;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #5 clock_i = ~clock_i;
  bcdm_tuner #(.REF_HALF(REF_P / 2)) u_tuner (
    .clock_i(clock_i), .low_digit_lines_o(lo_d),
    .high_digit_lines_o(hi_d), .chip_select_n_o(cs_n),
    .set_zero_n_o(sz_n), .set_one_n_o(so_n), .timing_reference_o(ref_c)
  );
  bcdm_core u_dut (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_r),
    .low_digit_lines_i(lo_d), .high_digit_lines_i(hi_d),
    .chip_select_n_i(cs_n), .set_zero_n_i(sz_n), .set_one_n_i(so_n),
    .timing_reference_input_i(ref_c), .data_out_o(data_out_o),
    .altering_o(altering_o)
  );
  task automatic test_done();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  // settle past the edge before looking
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wait_alt(input logic v, input int lim, output int n);
    n = 0;
    while (altering_o !== v && n < lim) begin
      step(1);
      n++;
    end
  endtask
  task automatic read_bit(input logic [7:0] a, input logic exp);
    u_tuner.set_addr(a);
    step(SETUP);
    check("idle output", 1'h0, data_out_o);
    u_tuner.select(1'h0);
    step(8);
    check("read data", exp, data_out_o);
    step(40);
    check("held data", exp, data_out_o);
    u_tuner.select(1'h1);
    step(6);
    check("deselected output", 1'h0, data_out_o);
  endtask
  task automatic alter(input logic [7:0] a, input logic one,
                       input logic hold, input logic [7:0] a2,
                       input logic sel);
    int n;
    logic long_enough;
    u_tuner.set_addr(a);
    step(SETUP);
    u_tuner.contact(one, ~one);
    // debounce window spans 2.5 to 7.5 nominal reference periods
    step(2 * REF_P + REF_P / 2);
    check("early alteration", 1'h0, altering_o);
    wait_alt(1'h1, 5 * REF_P, n);
    check("alteration start", 1'h1, altering_o);
    if (!hold) begin
      u_tuner.contact(1'h1, 1'h1);
    end
    if (sel) begin
      u_tuner.select(1'h0);
    end else begin
      u_tuner.set_addr(a2);
    end
    step(REF_P);
    check("output in alteration", 1'h0, data_out_o);
    wait_alt(1'h0, 45 * REF_P, n);
    check("alteration end", 1'h0, altering_o);
    // 200 ms is forty nominal reference periods
    long_enough = (n + REF_P + 2 >= 40 * REF_P);
    check("alteration length", 1'h1, long_enough);
    if (sel) begin
      step(3 * REF_P - 10);
      check("lockout output", 1'h0, data_out_o);
      n = 0;
      while (data_out_o !== one && n < REF_P) begin
        step(1);
        n++;
      end
      check("read after alteration", one, data_out_o);
      u_tuner.select(1'h1);
    end
    step(8 * REF_P);
    check("single alteration", 1'h0, altering_o);
    u_tuner.contact(1'h1, 1'h1);
    step(5 * REF_P);
  endtask
  // clock enable low must freeze the held read data
  task automatic freeze();
    u_tuner.set_addr(8'h02);
    step(SETUP);
    u_tuner.select(1'h0);
    step(8);
    check("read before freeze", 1'h1, data_out_o);
    @(posedge clock_i);
    ce_r <= 1'h0;
    u_tuner.select(1'h1);
    step(20);
    check("frozen output", 1'h1, data_out_o);
    @(posedge clock_i);
    ce_r <= 1'h1;
    step(6);
    check("thawed output", 1'h0, data_out_o);
  endtask
  task automatic press(input logic [7:0] a, input logic z, input logic o);
    u_tuner.set_addr(a);
    step(SETUP);
    u_tuner.contact(z, o);
    step(12 * REF_P);
    u_tuner.contact(1'h1, 1'h1);
    step(48 * REF_P);
  endtask
  task automatic no_start();
    u_tuner.contact(1'h0, 1'h0);
    step(8 * REF_P);
    check("both contacts low", 1'h0, altering_o);
    u_tuner.contact(1'h1, 1'h1);
    step(REF_P);
    u_tuner.contact(1'h1, 1'h0);
    step(REF_P + 10);
    u_tuner.contact(1'h1, 1'h1);
    step(6 * REF_P);
    check("interrupted closure", 1'h0, altering_o);
  endtask
  initial begin
    step(95000);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'h0;
    read_bit(8'h02, 1'h0);
    read_bit(8'h83, 1'h0);
    no_start();
    alter(8'h02, 1'h1, 1'h1, 8'h02, 1'h0);
    read_bit(8'h02, 1'h1);
    read_bit(8'h03, 1'h0);
    alter(8'h83, 1'h1, 1'h0, 8'h47, 1'h0);
    read_bit(8'h83, 1'h1);
    read_bit(8'h47, 1'h0);
    alter(8'h05, 1'h1, 1'h0, 8'h05, 1'h1);
    alter(8'h83, 1'h0, 1'h0, 8'h83, 1'h0);
    read_bit(8'h83, 1'h0);
    press(8'h1A, 1'h1, 1'h0);
    press(8'h00, 1'h0, 1'h1);
    read_bit(8'h02, 1'h1);
    freeze();
    read_bit(8'h20, 1'h0);
    read_bit(8'h84, 1'h0);
    test_done();
  end
endmodule

/* verilog/bcdm_core.sv */
`timescale 1ns/100ps
module bcdm_core
  import bcdm_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [3:0] low_digit_lines_i,
  input wire logic [3:0] high_digit_lines_i,
  input wire logic chip_select_n_i,
  input wire logic set_zero_n_i,
  input wire logic set_one_n_i,
  input wire logic timing_reference_input_i,
  output logic data_out_o,
  output logic altering_o
);
  typedef enum logic [4:0] {
    ST_ARMED   = 5'h01,
    ST_DEBOUNC = 5'h02,
    ST_ALTER   = 5'h04,
    ST_RELEASE = 5'h08,
    ST_LOCKOUT = 5'h10
  } bcdm_state_t;

  bcdm_state_t state_ff;
  bcdm_state_t nxt_state;
  logic [DEPTH-1:0] store_ff;
  logic [7:0] tick_cnt_ff;
  logic [6:0] alter_idx_ff;
  logic alter_ok_ff;
  logic alter_val_ff;
  logic data_ff;
  logic alter_ff;
  logic read_pend_ff;
  logic [16:0] access_cnt_ff;
  logic cs_last_ff;
  logic [2:0] sync_q;
  logic cs_n;
  logic sz_n;
  logic so_n;
  logic ref_s;
  logic tick;
  logic run;
  logic cs_fall;
  logic [6:0] cur_idx;
  logic cur_ok;
  logic one_low;
  logic both_high;

  // BCD address to bit index; flag says address is in range
  function automatic logic [7:0] bcd_index(input logic [3:0] lo,
                                           input logic [3:0] hi);
    logic [7:0] bin;
    logic ok;
    bin = 8'h00;
    ok = (lo <= 4'h9) && (hi <= 4'h9);
    bin = {4'h0, hi} * 8'h0A + {4'h0, lo};
    ok = ok && (bin >= {1'b0, ADDR_MIN}) && (bin <= {1'b0, ADDR_MAX});
    bin = bin - {1'b0, ADDR_MIN};
    bcd_index = {ok, bin[6:0]};
  endfunction

  bcdm_sync #(.W(3), .INIT(3'h7)) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({chip_select_n_i, set_zero_n_i, set_one_n_i}),
    .q_o(sync_q)
  );
  assign cs_n = sync_q[2];
  assign sz_n = sync_q[1];
  assign so_n = sync_q[0];

  logic ref_q;
  bcdm_sync #(.W(1), .INIT(1'b0)) u_ref_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(timing_reference_input_i),
    .q_o(ref_q)
  );
  assign ref_s = ref_q;

  // timer idles in armed state whenever no read runs, whatever the set inputs do
  assign run = (state_ff != ST_ARMED) || read_pend_ff;
  bcdm_tick u_tick (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(run),
    .ref_i(ref_s),
    .tick_o(tick)
  );

  logic [7:0] dec;
  assign dec = bcd_index(low_digit_lines_i, high_digit_lines_i);
  assign cur_idx = dec[6:0];
  assign cur_ok = dec[7];
  assign one_low = sz_n ^ so_n;
  assign both_high = sz_n & so_n;
  assign cs_fall = cs_last_ff & ~cs_n;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_ARMED: begin
        if (one_low) begin
          nxt_state = ST_DEBOUNC;
        end
      end
      ST_DEBOUNC: begin
        if (!one_low) begin
          nxt_state = ST_ARMED;
        end else if (tick && tick_cnt_ff == DEBOUNCE_TICKS - 8'h01) begin
          nxt_state = ST_ALTER;
        end
      end
      ST_ALTER: begin
        if (tick && tick_cnt_ff == ALTER_TICKS - 8'h01) begin
          nxt_state = ST_LOCKOUT;
        end
      end
      ST_LOCKOUT: begin
        if (tick && tick_cnt_ff == LOCKOUT_TICKS - 8'h01) begin
          nxt_state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (both_high && tick && tick_cnt_ff == RELEASE_TICKS - 8'h01) begin
          nxt_state = ST_ARMED;
        end
      end
      default: nxt_state = ST_ARMED;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_ARMED;
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  // period counter; restarts on state change, and on release if a set
  // input goes low again
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_ff <= 8'h00;
    end else if (ce_i) begin
      if (nxt_state != state_ff) begin
        tick_cnt_ff <= 8'h00;
      end else if (state_ff == ST_RELEASE && !both_high) begin
        tick_cnt_ff <= 8'h00;
      end else if (tick) begin
        tick_cnt_ff <= tick_cnt_ff + 8'h01;
      end
    end
  end

  // latch target at alteration start
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      alter_idx_ff <= 7'h00;
      alter_ok_ff <= 1'b0;
      alter_val_ff <= 1'b0;
    end else if (ce_i) begin
      if (state_ff == ST_DEBOUNC && nxt_state == ST_ALTER) begin
        alter_idx_ff <= cur_idx;
        alter_ok_ff <= cur_ok;
        alter_val_ff <= ~so_n;
      end
    end
  end

  // stored bits, written once at alteration end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      store_ff <= {DEPTH{STORE_RESET}};
    end else if (ce_i) begin
      if (state_ff == ST_ALTER && nxt_state == ST_LOCKOUT && alter_ok_ff) begin
        store_ff[alter_idx_ff] <= alter_val_ff;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cs_last_ff <= 1'b1;
    end else if (ce_i) begin
      cs_last_ff <= cs_n;
    end
  end

  // pending read: set on select fall outside alteration, kept over lockout
  logic blocked;
  assign blocked = (state_ff == ST_ALTER) || (state_ff == ST_LOCKOUT);
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      read_pend_ff <= 1'b0;
      access_cnt_ff <= 17'h00000;
    end else if (ce_i) begin
      if (cs_n || nxt_state == ST_ALTER) begin
        read_pend_ff <= 1'b0;
      end else if (cs_fall && state_ff != ST_ALTER) begin
        read_pend_ff <= 1'b1;
      end else if (state_ff == ST_LOCKOUT && nxt_state == ST_RELEASE) begin
        read_pend_ff <= 1'b1;
      end else if (read_pend_ff && !blocked) begin
        read_pend_ff <= 1'b0;
      end
      if (cs_n) begin
        access_cnt_ff <= 17'h00000;
      end else if (access_cnt_ff != 17'h1FFFF) begin
        access_cnt_ff <= access_cnt_ff + 17'h00001;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      data_ff <= 1'b0;
    end else if (ce_i) begin
      if (cs_n || blocked || nxt_state == ST_ALTER) begin
        data_ff <= 1'b0;
      end else if (read_pend_ff && cur_ok) begin
        data_ff <= store_ff[cur_idx];
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      alter_ff <= 1'b0;
    end else if (ce_i) begin
      alter_ff <= (nxt_state == ST_ALTER);
    end
  end

  assign data_out_o = data_ff;
  assign altering_o = alter_ff;

  a_out_low_cs: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && $past(cs_n) && $past(ce_i) |-> !data_out_o)
    else $error("data out high while select high");

  a_out_low_alt: assert property (@(posedge clock_i) disable iff (rst_i)
    state_ff == ST_ALTER |-> !data_out_o)
    else $error("data out high during alteration");

  a_latch_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    state_ff == ST_ALTER && $past(state_ff) == ST_ALTER |->
    $stable(alter_idx_ff) && $stable(alter_val_ff))
    else $error("alteration target moved");

  a_start_one: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && state_ff == ST_DEBOUNC && nxt_state == ST_ALTER |-> one_low)
    else $error("alteration without single set input");

  sequence s_alt_end;
    ce_i && state_ff == ST_ALTER && nxt_state == ST_LOCKOUT;
  endsequence
  a_alter_len: assert property (@(posedge clock_i) disable iff (rst_i)
    s_alt_end |-> tick_cnt_ff == ALTER_TICKS - 8'h01)
    else $error("alteration too short");

  a_store_val: assert property (@(posedge clock_i) disable iff (rst_i)
    s_alt_end and alter_ok_ff |=> store_ff[alter_idx_ff] == alter_val_ff)
    else $error("stored bit wrong");

  a_lock_read: assert property (@(posedge clock_i) disable iff (rst_i)
    state_ff == ST_LOCKOUT |-> !data_out_o)
    else $error("read during lockout");

  a_bad_addr: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && !cur_ok && !cs_n && !blocked && nxt_state != ST_ALTER
    |=> $stable(data_out_o))
    else $error("out of range address moved output");

  a_timer_idle: assert property (@(posedge clock_i) disable iff (rst_i)
    state_ff == ST_ARMED && !read_pend_ff |=> !tick)
    else $error("timer ran while idle");

  // a read started outside alteration and lockout is done within the access time
  a_read_time: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && !blocked && !$past(blocked) &&
    access_cnt_ff == 17'(READ_ACCESS_CYC) |-> !read_pend_ff)
    else $error("read data later than access time");
endmodule

/* verilog/bcdm_sync.sv */
`timescale 1ns/100ps
module bcdm_sync
  import bcdm_pkg::*;
#(
  parameter int unsigned W = 3,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= INIT;
      q_ff <= INIT;
    end else if (ce_i) begin
      meta_ff <= d_i;
      q_ff <= meta_ff;
    end
  end

  assign q_o = q_ff;
endmodule

/* verilog/bcdm_tick.sv */
`timescale 1ns/100ps
module bcdm_tick
  import bcdm_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic ref_i,
  output logic tick_o
);
  // rising edge of the synchronised timing reference while timer runs
  logic last_ff;
  logic tick_ff;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      last_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else if (ce_i) begin
      last_ff <= ref_i;
      tick_ff <= run_i & ref_i & ~last_ff;
    end
  end

  assign tick_o = tick_ff;
endmodule
